// ### ledt_timebase.sv
// Purpose: Time base of the RGB LED PWM driver: prescaler, flick rate, LFSR, blink ON timer.
// Assumes: One system clock of 4 to 64 MHz; write-only LED control bus.
// Notes: Blink ON starts the clock after the start strobe, not at a tick, so the ON time may run up to one tick short.
// Summary of operation
// (R1) Pseudo-random mode uses an 8-bit LFSR, x^8+x^5+x^3+x+1.
// (R2) Divisor is control bits 1:0 above the 8-bit prescale register.
// (R3) Writer loads Fsys/64 kHz minus one; tick every N+1 clocks.
// (R4) Flick rate 125 Hz or 250 Hz from the tick, picked by bit 6.
// (R5) Prescaler works for any clock 4 to 64 MHz with matching divisor.
// (R6) Blink ON phase lasts ON-time register value times 32 ms.
// (R7) ON time spans 0 to 8.16 s in 32 ms steps; zero gives none.
// (R8) Prescale register is loaded only by bus writes; no read path.
// (R9) ON-time register is loaded only by bus writes; whole byte counts.
// (R10) Flick select clear gives 125 Hz, set gives 250 Hz.
// (R11) Bit 2 clear gives linear square pulse, set gives LFSR pulse.
// (R12) Prescale register at address 1001, ON-time register at 1010.
// (R13) One 32 ms step is 2048 ticks; timer counts whole steps.
`timescale 1ns/100ps
`default_nettype none
`include "ledt_params.svh"
module ledt_timebase
    import ledt_pkg::*;
#(
    parameter int STEP_TICKS = `LEDT_STEP_TICKS
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] DAT_I,
    input wire logic WE_I,
    input wire logic BLINK_START_I,
    output logic TICK_O,
    output logic FLICK_O,
    output logic [7:0] PWM_PHASE_O,
    output logic RANDOM_MODE_O,
    output logic BLINK_ON_O,
    output logic BLINK_DONE_O
);
    localparam int STEP_W = $clog2(STEP_TICKS);

    ledt_tick_if tb ();

    logic [7:0] driver_control;
    logic [7:0] clock_prescale_low;
    logic [7:0] blink_on_time;
    logic [7:0] next_driver_control;
    logic [7:0] next_clock_prescale_low;
    logic [7:0] next_blink_on_time;

    logic [8:0] flick_count;
    logic [8:0] next_flick_count;
    logic [7:0] lfsr;
    logic [7:0] next_lfsr;
    logic [7:0] phase;
    logic [7:0] next_phase;
    logic flick;
    logic next_flick;
    logic flick_rate_select;
    logic random_mode;
    logic flick_end;
    logic step_phase;

    ledt_blink_t state;
    ledt_blink_t next_state;
    logic [7:0] on_step_count;
    logic [7:0] next_on_step_count;
    logic [STEP_W-1:0] sub_count;
    logic [STEP_W-1:0] next_sub_count;
    logic done;
    logic next_done;

    // Writes only; the bus has no read data, so nothing here is readable.
    always_comb begin
        next_driver_control = driver_control;
        next_clock_prescale_low = clock_prescale_low;
        next_blink_on_time = blink_on_time;
        if (WE_I) begin
            if (ADDR_I == `LEDT_ADDR_CTRL) begin
                next_driver_control = DAT_I;
            // (R8) (R12) Prescale write decode.
            end else if (ADDR_I == `LEDT_ADDR_PRESCALE) begin
                next_clock_prescale_low = DAT_I;
            // (R9) (R12) ON-time write decode.
            end else if (ADDR_I == `LEDT_ADDR_ON_TIME) begin
                next_blink_on_time = DAT_I;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            driver_control <= `LEDT_CTRL_RST;
            clock_prescale_low <= `LEDT_PRESCALE_RST;
            blink_on_time <= `LEDT_ON_TIME_RST;
        end else begin
            driver_control <= next_driver_control;
            clock_prescale_low <= next_clock_prescale_low;
            blink_on_time <= next_blink_on_time;
        end
    end

    // (R2) Ten-bit divisor assembly.
    assign tb.divisor = {driver_control[`LEDT_CTRL_HIGH_MSB:`LEDT_CTRL_HIGH_LSB],
                         clock_prescale_low};

    // (R5) Full 10-bit range prescaler.
    ledt_prescaler u_prescaler (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .tb(tb.gen)
    );

    assign flick_rate_select = driver_control[`LEDT_CTRL_FLICK_RATE_SELECT_BIT];
    assign random_mode = driver_control[`LEDT_CTRL_MODE_BIT];

    // (R4) (R10) Flick period of 512 or 256 ticks.
    assign flick_end = (flick_count[7:0] == 8'hFF) && (flick_rate_select || flick_count[8]);
    // At 125 Hz the 256 phase steps each take two ticks.
    assign step_phase = flick_rate_select || flick_count[0];

    always_comb begin
        next_flick_count = flick_count;
        next_lfsr = lfsr;
        next_flick = 1'b0;
        next_phase = phase;
        if (tb.tick) begin
            next_flick_count = flick_end ? 9'h000 : flick_count + 9'h001;
            next_flick = flick_end;
            if (flick_end) begin
                next_lfsr = `LEDT_LFSR_SEED;
            end else if (step_phase) begin
                // (R1) LFSR feedback taps.
                next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[4] ^ lfsr[2] ^ lfsr[0]};
            end
        end
        // (R11) Square or spread-spectrum phase.
        if (random_mode) begin
            next_phase = next_lfsr;
        end else if (flick_rate_select) begin
            next_phase = next_flick_count[7:0];
        end else begin
            next_phase = next_flick_count[8:1];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            flick_count <= 9'h000;
            lfsr <= `LEDT_LFSR_SEED;
            flick <= 1'b0;
            phase <= 8'h00;
        end else begin
            flick_count <= next_flick_count;
            lfsr <= next_lfsr;
            flick <= next_flick;
            phase <= next_phase;
        end
    end

    // (R6) (R7) (R13) Blink ON timer in 2048-tick steps.
    always_comb begin
        next_state = state;
        next_on_step_count = on_step_count;
        next_sub_count = sub_count;
        next_done = 1'b0;
        case (state)
            LEDT_IDLE: begin
                if (BLINK_START_I) begin
                    next_on_step_count = blink_on_time;
                    next_sub_count = '0;
                    // A zero count still reports completion, with no ON time.
                    next_state = (blink_on_time == 8'h00) ? LEDT_END : LEDT_ON;
                end
            end
            LEDT_ON: begin
                if (tb.tick) begin
                    if (sub_count == STEP_W'(STEP_TICKS - 1)) begin
                        next_sub_count = '0;
                        next_on_step_count = on_step_count - 8'h01;
                        if (on_step_count == 8'h01) begin
                            next_state = LEDT_END;
                        end
                    end else begin
                        next_sub_count = sub_count + STEP_W'(1);
                    end
                end
            end
            LEDT_END: begin
                next_done = 1'b1;
                next_state = LEDT_IDLE;
            end
            default: begin
                next_state = LEDT_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state <= LEDT_IDLE;
            on_step_count <= 8'h00;
            sub_count <= '0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            on_step_count <= next_on_step_count;
            sub_count <= next_sub_count;
            done <= next_done;
        end
    end

    assign TICK_O = tb.tick;
    assign FLICK_O = flick;
    assign PWM_PHASE_O = phase;
    assign RANDOM_MODE_O = random_mode;
    assign BLINK_ON_O = (state == LEDT_ON);
    assign BLINK_DONE_O = done;
endmodule // ledt_timebase
`default_nettype wire

// ### ledt_params.svh
// Purpose: Constants of the LED PWM time base: bus addresses, field positions, timing.
// Assumes: A 4-bit LED control bus address and 8-bit write data.
// Notes: Times are kept in their own units; tick counts derive from them.
`ifndef LEDT_PARAMS_SVH
`define LEDT_PARAMS_SVH

`define LEDT_ADDR_CTRL 4'h8
`define LEDT_ADDR_PRESCALE 4'h9
`define LEDT_ADDR_ON_TIME 4'hA

`define LEDT_CTRL_FLICK_RATE_SELECT_BIT 6
`define LEDT_CTRL_MODE_BIT 2
`define LEDT_CTRL_HIGH_MSB 1
`define LEDT_CTRL_HIGH_LSB 0

`define LEDT_CTRL_RST 8'h00
`define LEDT_PRESCALE_RST 8'h00
`define LEDT_ON_TIME_RST 8'h00
`define LEDT_LFSR_SEED 8'h01

`define LEDT_TICK_HZ 64000
`define LEDT_FLICK_LOW_HZ 125
`define LEDT_FLICK_HIGH_HZ 250
`define LEDT_STEP_MS 32
`define LEDT_FLICK_LOW_TICKS (`LEDT_TICK_HZ / `LEDT_FLICK_LOW_HZ)
`define LEDT_FLICK_HIGH_TICKS (`LEDT_TICK_HZ / `LEDT_FLICK_HIGH_HZ)
`define LEDT_STEP_TICKS ((`LEDT_STEP_MS * `LEDT_TICK_HZ) / 1000)

`endif

// ### ledt_pkg.sv
// Purpose: Types shared by the LED PWM time base.
// Assumes: Nothing beyond the parameter header.
// Notes: Blink states step IDLE to ON to END one bit at a time; the zero ON-time jump from IDLE to END and the return from END to IDLE flip two bits.
package ledt_pkg;

    typedef enum logic [1:0] {
        LEDT_IDLE = 2'b00,
        LEDT_ON = 2'b01,
        LEDT_END = 2'b11
    } ledt_blink_t;

    typedef logic [9:0] ledt_divisor_t;

endpackage

// ### ledt_tick_if.sv
// Purpose: Carries the prescale divisor to the prescaler and its tick back.
// Assumes: One clock domain.
// Notes: None.
`timescale 1ns/100ps
`default_nettype none
interface ledt_tick_if;
    import ledt_pkg::*;
    ledt_divisor_t divisor;
    logic tick;
    modport ctrl (output divisor, input tick);
    modport gen (input divisor, output tick);
endinterface
`default_nettype wire

// ### ledt_prescaler.sv
// Purpose: Divides the system clock down to the 64 kHz tick.
// Assumes: Divisor N gives one tick every N+1 clocks.
// Notes: A divisor lowered below the count wraps at once, never runs to 1023.
`timescale 1ns/100ps
`default_nettype none
module ledt_prescaler
    import ledt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    ledt_tick_if.gen tb
);
    ledt_divisor_t count;
    ledt_divisor_t next_count;
    logic tick;
    logic next_tick;

    // (R3) Tick every N+1 clocks.
    always_comb begin
        next_tick = 1'b0;
        next_count = count + 10'h001;
        if (count >= tb.divisor) begin
            next_tick = 1'b1;
            next_count = 10'h000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= 10'h000;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end

    assign tb.tick = tick;
endmodule // ledt_prescaler
`default_nettype wire

// ### ledt_writer.sv
// Purpose: Fabric-side model that writes the LED control bus.
// Assumes: Write-only bus, one strobe cycle per write.
// Notes: Idle lines carry inverted values so stale data never looks valid.
`timescale 1ns/100ps
`default_nettype none
module ledt_writer (
    input wire logic clk_i,
    output logic [3:0] addr_o,
    output logic [7:0] dat_o,
    output logic we_o
);
    initial begin
        addr_o = 4'h0;
        dat_o = 8'h00;
        we_o = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        dat_o <= d;
        we_o <= 1'b1;
        @(posedge clk_i);
        addr_o <= ~a;
        dat_o <= ~d;
        we_o <= 1'b0;
    endtask
endmodule // ledt_writer
`default_nettype wire

// ### ledt_timebase_chk.sv
// Purpose: Port checker of the LED PWM time base.
// Assumes: Register values mirrored from bus writes.
// Notes: A period cut by a write is skipped, as the change may land mid-period.
`timescale 1ns/100ps
`default_nettype none
module ledt_timebase_chk #(
    parameter int STEP_TICKS = 4
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] DAT_I,
    input wire logic WE_I,
    input wire logic BLINK_START_I,
    input wire logic TICK_O,
    input wire logic FLICK_O,
    input wire logic [7:0] PWM_PHASE_O,
    input wire logic RANDOM_MODE_O,
    input wire logic BLINK_ON_O,
    input wire logic BLINK_DONE_O
);
    logic [7:0] ctl, pre, ont, v, ph;
    logic [9:0] cnt, ftk;
    logic [17:0] otk;
    logic chg, fchg, seen, fseen, idle_r, lok;
    wire logic idle = idle_r | BLINK_DONE_O;
    wire logic acc = BLINK_START_I & idle;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            {ctl, pre, ont, v, ph, cnt, ftk, otk, chg, fchg, seen, fseen, lok} <= '0;
            idle_r <= 1'b1;
        end else begin
            if (WE_I && ADDR_I == 4'h8) ctl <= DAT_I;
            if (WE_I && ADDR_I == 4'h9) pre <= DAT_I;
            if (WE_I && ADDR_I == 4'hA) ont <= DAT_I;
            if (acc) v <= ont;
            chg <= (WE_I && ADDR_I[3:1] == 3'h4) || (chg && !TICK_O);
            fchg <= (WE_I && ADDR_I == 4'h8) || (fchg && !FLICK_O);
            seen <= seen | TICK_O;
            fseen <= fseen | FLICK_O;
            cnt <= TICK_O ? 10'h000 : cnt + 10'h001;
            ftk <= FLICK_O ? 10'(TICK_O) : ftk + 10'(TICK_O);
            otk <= BLINK_ON_O ? otk + 18'(TICK_O) : 18'h00000;
            idle_r <= idle & !BLINK_START_I;
            ph <= PWM_PHASE_O;
            lok <= RANDOM_MODE_O & (lok | FLICK_O);
        end
    end
    sequence s_end;
        !BLINK_ON_O ##1 BLINK_DONE_O;
    endsequence
    tick_period_a: assert property (
        TICK_O && seen && !chg |-> cnt == {ctl[1:0], pre}) else $error("Tick period wrong.");
    flick_period_a: assert property (
        FLICK_O && fseen && !fchg |-> ftk == (ctl[6] ? 10'h100 : 10'h200))
        else $error("Flick period wrong.");
    random_mode_a: assert property (
        RANDOM_MODE_O == ctl[2]) else $error("Mode bit wrong.");
    lfsr_step_a: assert property (
        lok && RANDOM_MODE_O && !FLICK_O && PWM_PHASE_O != ph
        |-> PWM_PHASE_O == {ph[6:0], ^(ph & 8'h95)}) else $error("LFSR step wrong.");
    // The phase lags the mode bit by one clock, so a fresh switch is skipped.
    linear_phase_a: assert property (
        FLICK_O && !RANDOM_MODE_O && !$past(RANDOM_MODE_O) |-> PWM_PHASE_O == 8'h00)
        else $error("Linear phase not restarted.");
    on_start_a: assert property (
        acc && ont != 8'h00 |=> BLINK_ON_O) else $error("ON phase missing.");
    zero_on_a: assert property (
        acc && ont == 8'h00 |=> s_end) else $error("Zero ON time wrong.");
    on_length_a: assert property (
        $fell(BLINK_ON_O) |-> otk == 18'(v) * STEP_TICKS) else $error("ON length wrong.");
    done_after_a: assert property (
        $fell(BLINK_ON_O) |-> s_end) else $error("Done pulse missing.");
    done_pulse_a: assert property (
        BLINK_DONE_O |=> !BLINK_DONE_O) else $error("Done pulse too long.");
endmodule // ledt_timebase_chk
bind ledt_timebase ledt_timebase_chk #(.STEP_TICKS(STEP_TICKS)) i_chk (.CLK_I(CLK_I),
    .RST_I(RST_I), .ADDR_I(ADDR_I), .DAT_I(DAT_I), .WE_I(WE_I), .BLINK_START_I(BLINK_START_I),
    .TICK_O(TICK_O), .FLICK_O(FLICK_O), .PWM_PHASE_O(PWM_PHASE_O),
    .RANDOM_MODE_O(RANDOM_MODE_O), .BLINK_ON_O(BLINK_ON_O), .BLINK_DONE_O(BLINK_DONE_O));
`default_nettype wire

// ### ledt_timebase_tb_top.sv
// Purpose: Self-checking bench of the LED PWM time base.
// Assumes: 100 MHz clock and a short blink step.
// Notes: Divisors stay small, since the real formula exceeds 10 bits here.
`timescale 1ns/100ps
`default_nettype none
module ledt_timebase_tb_top;
    localparam int STEP = 4;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0;
    logic [3:0] addr;
    logic [7:0] dat, phase;
    logic we, tick, flick, rmode, on, done;
    int failures = 0, check_count = 0;
    always #5 clk = ~clk;
    ledt_writer i_wr (.clk_i(clk), .addr_o(addr), .dat_o(dat), .we_o(we));
    ledt_timebase #(.STEP_TICKS(STEP)) i_dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
        .DAT_I(dat), .WE_I(we), .BLINK_START_I(start), .TICK_O(tick), .FLICK_O(flick),
        .PWM_PHASE_O(phase), .RANDOM_MODE_O(rmode), .BLINK_ON_O(on), .BLINK_DONE_O(done));
    task automatic give_verdict();
        $display("Checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int s, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (!((s == 0) ? tick === 1'b1 : flick === 1'b1) && n < 2000);
        if (n >= 2000) begin
            failures++;
            give_verdict();
        end
    endtask
    task automatic s_tick();
        int n;
        i_wr.wr(4'h9, 8'h02);
        wt(0, n);
        wt(0, n);
        chk(16'(n), 16'h0003);
        i_wr.wr(4'h8, 8'h01);
        i_wr.wr(4'h9, 8'h00);
        wt(0, n);
        wt(0, n);
        chk(16'(n), 16'h0101);
    endtask
    task automatic s_flick();
        int n;
        i_wr.wr(4'h9, 8'h00);
        for (int k = 0; k < 2; k++) begin
            i_wr.wr(4'h8, (k == 0) ? 8'h40 : 8'h00);
            wt(1, n);
            wt(1, n);
            chk(16'(n), (k == 0) ? 16'h0100 : 16'h0200);
            chk(16'(phase), 16'h0000);
        end
    endtask
    task automatic s_lfsr();
        int n;
        logic [7:0] e;
        i_wr.wr(4'h8, 8'h44);
        #1;
        chk(16'(rmode), 16'h0001);
        wt(1, n);
        e = 8'h01;
        repeat (8) begin
            chk(16'(phase), 16'(e));
            e = {e[6:0], ^(e & 8'h95)};
            @(posedge clk);
            #1;
        end
    endtask
    // The unmapped write must leave the ON time untouched.
    task automatic s_blink(input logic [7:0] v);
        int n;
        int k;
        n = 0;
        i_wr.wr(4'hA, v);
        i_wr.wr(4'hB, 8'h07);
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (k = 0; k < 1200; k++) begin
            #1;
            if (on === 1'b1) n++;
            if (done === 1'b1) break;
            @(posedge clk);
        end
        chk(16'(k < 1200), 16'h0001);
        chk(16'(n), 16'(v) * 16'(STEP));
        if (k >= 1200) begin
            give_verdict();
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        s_tick();
        s_flick();
        s_lfsr();
        s_blink(8'h00);
        s_blink(8'h01);
        s_blink(8'hFF);
        give_verdict();
    end
endmodule // ledt_timebase_tb_top
`default_nettype wire
